// *** rtl/pcl_core.sv ***
// Purpose: Program counter and its next-address selection.
// Assumes: Decoder raises at most one load strobe per fetch cycle; strobes are on mclk.
// Notes: Operand inputs come from the same clock domain and need no synchronisers.
`timescale 1ns/1ps
`include "pcl_defines.svh"
module pcll_core
  import pcll_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire pcll_ctrl_t ctrl,
  input wire pcll_data_t data,
  output logic [`PCLL_PC_W-1:0] fetch_address,
  output logic [`PCLL_LOW_W-1:0] counter_low_byte,
  output pcll_load_t last_load
);
  typedef struct packed {
    logic [`PCLL_PC_W-1:0] pc;
    pcll_load_t load;
  } pcll_core_state_t;

  pcll_core_state_t state;
  pcll_core_state_t next_state;
  logic [`PCLL_UPPER_W-1:0] high_address_latch;
  logic [`PCLL_PC_W-1:0] advanced;
  logic [`PCLL_PC_W-1:0] working_offset;
  logic [`PCLL_PC_W-1:0] immediate_offset;
  logic [`PCLL_PC_W-1:0] branch_offset;
  logic [`PCLL_PC_W-1:0] branch_target;
  logic [`PCLL_PC_W-1:0] sequential_target;
  logic [`PCLL_PC_W-1:0] low_target;
  logic [`PCLL_PC_W-1:0] call_target;
  logic [`PCLL_PC_W-1:0] call_working_target;
  logic counter_moves;
  pcll_load_t kind;

  // Priority order picks one load kind. The decoder should never raise two strobes,
  // but a fixed order keeps the counter defined if it ever does.
  function automatic pcll_load_t pcll_select(input pcll_ctrl_t c);
    if (c.low_write) begin
      return PCLL_LOAD_LOW;
    end else if (c.call_direct) begin
      return PCLL_LOAD_CALL;
    end else if (c.call_working) begin
      return PCLL_LOAD_CALL_WORK;
    end else if (c.branch_working) begin
      return PCLL_LOAD_BRANCH_WORK;
    end else if (c.branch_immediate) begin
      return PCLL_LOAD_BRANCH_IMM;
    end else begin
      return PCLL_LOAD_SEQ;
    end
  endfunction : pcll_select

  // Every kind but plain sequencing replaces the counter even without a fetch strobe.
  function automatic logic pcll_is_load(input pcll_load_t k);
    return k != PCLL_LOAD_SEQ;
  endfunction : pcll_is_load

  // The whole latch stands above a low byte; the low-byte write and the computed call share this.
  function automatic logic [`PCLL_PC_W-1:0] pcll_join_latch(
    input logic [`PCLL_UPPER_W-1:0] upper,
    input logic [`PCLL_LOW_W-1:0] low
  );
    return {upper, low};
  endfunction : pcll_join_latch

  // A direct call keeps only the top four latch bits; its operand already covers bits 10..0.
  function automatic logic [`PCLL_PC_W-1:0] pcll_join_call(
    input logic [`PCLL_UPPER_W-1:0] upper,
    input logic [`PCLL_CALL_OP_W-1:0] operand
  );
    return {upper[`PCLL_CALL_LATCH_HI:`PCLL_CALL_LATCH_LO], operand};
  endfunction : pcll_join_call

  // The latch is a register, so a latch write in the same cycle as a load is seen one cycle later.
  pcll_latch u_latch (
    .mclk(mclk),
    .arst_n(arst_n),
    .write(ctrl.latch_write),
    .data(data.latch_data),
    .high_address_latch(high_address_latch)
  );

  assign kind = pcll_select(ctrl);
  assign counter_moves = ctrl.fetch || pcll_is_load(kind);
  assign advanced = state.pc + `PCLL_PC_ONE;

  // The working register is unsigned, so every offset bit above it is zero.
  for (genvar w = 0; w < `PCLL_PC_W; w++) begin : g_working_offset
    if (w < `PCLL_LOW_W) begin : g_value
      assign working_offset[w] = data.working[w];
    end else begin : g_zero
      assign working_offset[w] = 1'b0;
    end
  end

  // The immediate operand is signed; its top bit fills every offset bit above it.
  for (genvar i = 0; i < `PCLL_PC_W; i++) begin : g_immediate_offset
    if (i < `PCLL_BRANCH_OP_W) begin : g_value
      assign immediate_offset[i] = data.branch_operand[i];
    end else begin : g_sign
      assign immediate_offset[i] = data.branch_operand[`PCLL_BRANCH_OP_W-1];
    end
  end

  always_comb begin
    branch_offset = working_offset;
    if (kind == PCLL_LOAD_BRANCH_IMM) begin
      branch_offset = immediate_offset;
    end
  end

  pcll_adder u_adder (
    .base(advanced),
    .offset(branch_offset),
    .target(branch_target)
  );

  // Without a fetch strobe the counter holds, since the core is then stalled.
  assign sequential_target = ctrl.fetch ? advanced : state.pc;
  // An add into the low byte keeps the latch's block, so tables must not straddle 256 words.
  assign low_target = pcll_join_latch(high_address_latch, data.result);
  assign call_target = pcll_join_call(high_address_latch, data.call_operand);
  assign call_working_target = pcll_join_latch(high_address_latch, data.working);

  always_comb begin
    next_state = state;
    if (counter_moves) begin
      next_state.load = kind;
    end
    case (kind)
      PCLL_LOAD_SEQ: begin
        next_state.pc = sequential_target;
      end
      PCLL_LOAD_LOW: begin
        next_state.pc = low_target;
      end
      PCLL_LOAD_CALL: begin
        next_state.pc = call_target;
      end
      PCLL_LOAD_CALL_WORK: begin
        next_state.pc = call_working_target;
      end
      PCLL_LOAD_BRANCH_WORK, PCLL_LOAD_BRANCH_IMM: begin
        next_state.pc = branch_target;
      end
      default: begin
        next_state.pc = state.pc;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state.pc <= `PCLL_PC_RESET;
      state.load <= PCLL_LOAD_SEQ;
    end else begin
      state <= next_state;
    end
  end

  assign fetch_address = state.pc;
  assign counter_low_byte = state.pc[`PCLL_LOW_W-1:0];
  assign last_load = state.load;
endmodule : pcll_core

// *** rtl/pcl_defines.svh ***
// Purpose: Constants for the program counter load logic.
// Assumes: Included by the package and by every design file that needs widths or reset values.
// Notes: Definitions only.
`ifndef PCLL_DEFINES_SVH
`define PCLL_DEFINES_SVH
`define PCLL_PC_W 15
`define PCLL_UPPER_W 7
`define PCLL_LOW_W 8
`define PCLL_CALL_OP_W 11
`define PCLL_BRANCH_OP_W 9
`define PCLL_CALL_LATCH_HI 6
`define PCLL_CALL_LATCH_LO 3
`define PCLL_PC_RESET 15'h0000
`define PCLL_LATCH_RESET 7'h00
`define PCLL_PC_ONE 15'h0001
`endif

// *** rtl/pcl_pkg.sv ***
// Purpose: Types shared by the program counter load logic.
// Assumes: Header of constants is on the include path.
// Notes: Load kinds are one-hot.
`include "pcl_defines.svh"
package pcll_pkg;
  typedef enum logic [5:0] {
    PCLL_LOAD_SEQ = 6'h01,
    PCLL_LOAD_LOW = 6'h02,
    PCLL_LOAD_CALL = 6'h04,
    PCLL_LOAD_CALL_WORK = 6'h08,
    PCLL_LOAD_BRANCH_WORK = 6'h10,
    PCLL_LOAD_BRANCH_IMM = 6'h20
  } pcll_load_t;

  typedef struct packed {
    logic fetch;
    logic low_write;
    logic call_direct;
    logic call_working;
    logic branch_working;
    logic branch_immediate;
    logic latch_write;
  } pcll_ctrl_t;

  typedef struct packed {
    logic [`PCLL_LOW_W-1:0] working;
    logic [`PCLL_LOW_W-1:0] result;
    logic [`PCLL_CALL_OP_W-1:0] call_operand;
    logic [`PCLL_BRANCH_OP_W-1:0] branch_operand;
    logic [`PCLL_LOW_W-1:0] latch_data;
  } pcll_data_t;
endpackage : pcll_pkg

// *** rtl/pcl_latch.sv ***
// Purpose: High-address latch register written by the datapath.
// Assumes: Write strobe and data come from logic on mclk.
// Notes: Only its seven low bits exist; upper bit of the written byte is dropped.
`timescale 1ns/1ps
`include "pcl_defines.svh"
module pcll_latch
  import pcll_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic write,
  input wire logic [`PCLL_LOW_W-1:0] data,
  output logic [`PCLL_UPPER_W-1:0] high_address_latch
);
  typedef struct packed {
    logic [`PCLL_UPPER_W-1:0] latch;
  } pcll_latch_state_t;

  pcll_latch_state_t state;
  pcll_latch_state_t next_state;

  always_comb begin
    next_state = state;
    if (write) begin
      next_state.latch = data[`PCLL_UPPER_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state.latch <= `PCLL_LATCH_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign high_address_latch = state.latch;
endmodule : pcll_latch

// *** rtl/pcl_adder.sv ***
// Purpose: Full-width relative branch target adder.
// Assumes: Base is the counter after it advanced past the branch.
// Notes: Purely combinational; wraps within the counter width.
`timescale 1ns/1ps
`include "pcl_defines.svh"
module pcll_adder
  import pcll_pkg::*;
(
  input wire logic [`PCLL_PC_W-1:0] base,
  input wire logic [`PCLL_PC_W-1:0] offset,
  output logic [`PCLL_PC_W-1:0] target
);
  // Carry runs through all fifteen bits so a branch can leave its 256-word block.
  assign target = base + offset;
endmodule : pcll_adder

// *** test/pcl_core_props.sv ***
// Purpose: Port assertions for the counter load logic.
// Assumes: The latch is mirrored here from its write strobe.
// Notes: Lower loads are guarded by higher strobes, matching the core's priority.
`timescale 1ns/1ps
module pcll_core_props
  import pcll_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire pcll_ctrl_t ctrl,
  input wire pcll_data_t data,
  input wire logic [14:0] fetch_address,
  input wire logic [7:0] counter_low_byte,
  input wire pcll_load_t last_load
);
  logic [6:0] lat;
  wire [14:0] nx = fetch_address + 15'h0001;
  wire [14:0] work_target = nx + {7'h00, data.working};
  wire [14:0] imm_target = nx + {{6{data.branch_operand[8]}}, data.branch_operand};
  wire hi = ctrl.low_write | ctrl.call_direct | ctrl.call_working;
  wire ld = hi | ctrl.branch_working | ctrl.branch_immediate;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lat <= 7'h00;
    end else if (ctrl.latch_write) begin
      lat <= data.latch_data[6:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_set_latch;
    ctrl.latch_write;
  endsequence
  sequence s_set_latch_then_low;
    s_set_latch ##1 ctrl.low_write;
  endsequence
  property p_walk;
    s_set_latch_then_low |=> fetch_address[14:8] == $past(data.latch_data[6:0], 2);
  endproperty
  a_walk: assert property (p_walk) else $error("latch then low write");
  property p_rst; $rose(arst_n) |-> fetch_address == 15'h0000 && last_load == PCLL_LOAD_SEQ; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_low; ctrl.low_write |=> fetch_address == {$past(lat), $past(data.result)}; endproperty
  a_low: assert property (p_low) else $error("low write");
  property p_call; ctrl.call_direct && !ctrl.low_write |=> fetch_address == {$past(lat[6:3]), $past(data.call_operand)};
  endproperty
  a_call: assert property (p_call) else $error("direct call");
  property p_cw;
    ctrl.call_working && !ctrl.low_write && !ctrl.call_direct |=> fetch_address == {$past(lat), $past(data.working)};
  endproperty
  a_cw: assert property (p_cw) else $error("computed call");
  property p_brw; ctrl.branch_working && !hi |=> fetch_address == $past(work_target); endproperty
  a_brw: assert property (p_brw) else $error("working branch");
  property p_bra;
    ctrl.branch_immediate && !hi && !ctrl.branch_working |=> fetch_address == $past(imm_target);
  endproperty
  a_bra: assert property (p_bra) else $error("immediate branch");
  property p_seq; ctrl.fetch && !ld |=> fetch_address == $past(nx); endproperty
  a_seq: assert property (p_seq) else $error("sequential fetch");
  property p_byte; counter_low_byte == fetch_address[7:0]; endproperty
  a_byte: assert property (p_byte) else $error("low byte");
endmodule : pcll_core_props
bind pcll_core pcll_core_props pcll_core_props_inst (.mclk(mclk), .arst_n(arst_n), .ctrl(ctrl), .data(data),
  .fetch_address(fetch_address), .counter_low_byte(counter_low_byte), .last_load(last_load));

// *** test/pcl_decoder_model.sv ***
// Purpose: Decoder stand-in that turns an op code into one core strobe.
// Assumes: Op and value change at the falling edge.
// Notes: All operand fields share one value; op 7 is idle.
`timescale 1ns/1ps
module pcll_decoder_model
  import pcll_pkg::*;
(
  input wire logic [2:0] op,
  input wire logic [10:0] val,
  output pcll_ctrl_t ctrl,
  output pcll_data_t data
);
  // Only one strobe at a time, so priority between strobes is never relied on.
  assign ctrl = pcll_ctrl_t'(7'h40 >> op);
  assign data = {val[7:0], val[7:0], val, val[8:0], val[7:0]};
endmodule : pcll_decoder_model

// *** test/test_program_counter_load_logic.sv ***
// Purpose: Self-checking bench for the program counter load logic.
// Assumes: The decoder model makes the strobes from the bench's op code.
// Notes: An integer model is compared after every clock.
`timescale 1ns/1ps
module test_program_counter_load_logic;
  import pcll_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] op = 3'h7;
  logic [10:0] val = 11'h000;
  pcll_ctrl_t ctrl;
  pcll_data_t data;
  logic [14:0] fa;
  logic [7:0] lb;
  pcll_load_t ll;
  int errors = 0;
  int checked = 0;
  int pc = 0;
  int lat = 0;
  int kind = 1;
  int exp_q[$];
  always #50 mclk = ~mclk;
  pcll_decoder_model pcll_decoder_model_inst (.op(op), .val(val), .ctrl(ctrl), .data(data));
  pcll_core pcll_core_inst (.mclk(mclk), .arst_n(arst_n), .ctrl(ctrl), .data(data), .fetch_address(fa),
    .counter_low_byte(lb), .last_load(ll));
  task automatic report(input string n, input logic [14:0] e, input logic [14:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : report
  task automatic cmp_address(input logic [14:0] e);
    report("address", e, fa);
  endtask : cmp_address
  task automatic cmp_low_byte(input logic [7:0] e);
    report("low byte", {7'h00, e}, {7'h00, lb});
  endtask : cmp_low_byte
  task automatic cmp_kind(input logic [5:0] e);
    report("load kind", {9'h000, e}, {9'h000, ll});
  endtask : cmp_kind
  task automatic step(input int o, input int v);
    int e;
    op = o[2:0];
    val = v[10:0];
    @(negedge mclk);
    case (o)
      0: pc = pc + 1;
      1, 3: pc = lat * 256 + v % 256;
      2: pc = (lat / 8) * 2048 + v % 2048;
      4: pc = pc + 1 + v % 256;
      5: pc = pc + 1 + v % 512 - (v % 512 >= 256 ? 512 : 0);
      6: lat = v % 128;
      default: ;
    endcase
    // Masking after the sum models the 15-bit wrap for both directions.
    pc = pc & 32767;
    kind = o < 6 ? 1 << o : kind;
    exp_q.push_back(pc);
    e = exp_q.pop_front();
    cmp_address(e[14:0]);
    cmp_low_byte(e[7:0]);
    cmp_kind(kind[5:0]);
  endtask : step
  task automatic give_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  initial begin
    void'($urandom(32'h8e54));
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    cmp_address(15'h0000);
    cmp_kind(6'h01);
    step(6, 11'h07F);
    step(1, 11'h0FF);
    step(0, 11'h000);
    step(5, 11'h1FF);
    step(6, 11'h2A5);
    step(2, 11'h7FF);
    step(3, 11'h080);
    step(4, 11'h0FF);
    repeat (400) step($urandom % 8, $urandom % 2048);
    arst_n = 1'b0;
    pc = 0;
    lat = 0;
    kind = 1;
    step(7, 11'h000);
    arst_n = 1'b1;
    step(0, 11'h000);
    give_verdict();
  end
endmodule : test_program_counter_load_logic
